// [verilog/tcsr_pkg.sv]
// Shared constants of the tuner control and status register block.
// Assumes a 50 MHz system clock and a two-wire read port sampled by it.
package tcsr_pkg;

  // Clock and link timing
  localparam int SYS_CLK_HZ        = 50_000_000;
  localparam int LINK_PERIOD_NS    = 160;

  // Calibration settle counts in comparison-frequency cycles
  localparam int SETTLE_SHORT_CYC  = 28673;
  localparam int SETTLE_LONG_CYC   = 32769;
  localparam int SETTLE_CNT_W      = 16;

  // Field widths
  localparam int BOOST_W           = 4;
  localparam int CUTOFF_W          = 5;
  localparam int CUTOFF_MHZ_W      = 6;
  localparam int SWING_W           = 3;
  localparam int THRESH_W          = 2;
  localparam int BIAS_W            = 4;
  localparam int RATIO_W           = 5;
  localparam int LEVEL_W           = 2;
  localparam int ADDR_W            = 7;

  // Decode constants
  localparam logic [BOOST_W-1:0]      BOOST_FLAT_MAX  = 4'h4;
  localparam logic [CUTOFF_MHZ_W-1:0] CUTOFF_BASE_MHZ = 6'h05;
  localparam logic [RATIO_W-1:0]      RATIO_MIN       = 5'h00;
  localparam logic [RATIO_W-1:0]      RATIO_MAX       = 5'h1F;

  // Read map: byte offsets
  localparam logic [0:0] REG_STATUS_FLAGS = 1'h0;
  localparam logic [0:0] REG_LEVEL_RATIO  = 1'h1;

  // Status byte bit positions
  localparam int POS_POWER_ON      = 7;
  localparam int POS_LOCK          = 6;
  localparam int POS_TUNE_HIGH     = 5;
  localparam int POS_TUNE_LOW      = 4;
  localparam int POS_CAL_FAULT     = 3;
  // Level and ratio byte layout
  localparam int POS_MARKER        = 7;
  localparam int POS_LEVEL_LSB     = 5;
  localparam int POS_RATIO_LSB     = 0;
  localparam logic [2:0] STATUS_UNDEF = 3'h0;

  // Serial frame constants
  localparam logic [2:0] LAST_BIT  = 3'h7;
  localparam int SYNC_W            = 8;

  typedef enum logic [2:0] {
    TCSR_SER_IDLE  = 3'b000,
    TCSR_SER_ADDR  = 3'b001,
    TCSR_SER_AACK  = 3'b010,
    TCSR_SER_TX    = 3'b011,
    TCSR_SER_MACK  = 3'b100
  } tcsr_ser_e;

  typedef enum logic [1:0] {
    TCSR_CAL_IDLE  = 2'b00,
    TCSR_CAL_WAIT  = 2'b01,
    TCSR_CAL_JUDGE = 2'b10
  } tcsr_cal_e;

endpackage : tcsr_pkg

// [verilog/tcsr_top.sv]
// Control field decode, VCO calibration sequencer and two-wire read port
// of the tuner. Control fields arrive from the write-frame decoder on
// sys_clk; comp_tick is a one-cycle comparison-frequency enable.
//
// Functional notes
// (R1) Boost code 0..4 adds no gain, higher codes raise gain monotonically.
// (R2) Cut-off code maps linearly, 5 MHz plus code, up to 36 MHz.
// (R3) Input pad set attenuates LNA and loop-through; clear keeps normal gain.
// (R4) Pump current select bit 1 gives high current, 0 low current.
// (R5) Main pump test on lets force bits switch sink and source directly.
// (R6) Second pump test on: force 0 gives sink only, 1 source only.
// (R7) Pump select 0 enables first pump, 1 enables second pump.
// (R8) Master always programs oscillator swing to binary 100.
// (R9) Each port bit drives an open-drain output; 1 pulls down.
// (R10) Calibration waits 28673 or 32769 comparison cycles per applied code.
// (R11) Upper threshold select picks tune-high comparator level; 11 recommended.
// (R12) Lower threshold select picks tune-low comparator level; 01 recommended.
// (R13) Master always programs baseband bias trim to binary 1101.
// (R14) Read is START, address, ack, two data bytes each acked, STOP.
// (R15) Byte 0: power-on, lock, tune-high, tune-low, fault; low bits undefined.
// (R16) Byte 1: constant 1, input power code, live ratio; MSB first.
// (R17) Power-on flag set at supply ramp or dip, cleared after first read.
// (R18) Fault flag set when calibration steps ratio past minimum or maximum.
// (R19) Live ratio equals programmed code in manual, calibrated code in auto.
// (R20) Status snapshot taken at START so both bytes are consistent.
`timescale 1ns/1ps
module tcsr_top
  import tcsr_pkg::*;
#(
  parameter int SHORT_SETTLE = tcsr_pkg::SETTLE_SHORT_CYC,
  parameter int LONG_SETTLE  = tcsr_pkg::SETTLE_LONG_CYC
) (
  // Clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              rst_b,
  // Control fields from the write-frame decoder
  input  wire logic [tcsr_pkg::BOOST_W-1:0]      baseband_boost,
  input  wire logic [tcsr_pkg::CUTOFF_W-1:0]     cutoff_code,
  input  wire logic                              input_pad,
  input  wire logic                              pump_current_sel,
  input  wire logic                              main_pump_test,
  input  wire logic                              force_sink,
  input  wire logic                              force_source,
  input  wire logic                              second_pump_test,
  input  wire logic                              second_pump_force,
  input  wire logic                              pump_select,
  input  wire logic [tcsr_pkg::SWING_W-1:0]      oscillator_swing,
  input  wire logic [1:0]                        port_ctrl,
  input  wire logic                              settle_select,
  input  wire logic [tcsr_pkg::THRESH_W-1:0]     upper_threshold_sel,
  input  wire logic [tcsr_pkg::THRESH_W-1:0]     lower_threshold_sel,
  input  wire logic [tcsr_pkg::BIAS_W-1:0]       baseband_bias_trim,
  input  wire logic                              cal_manual,
  input  wire logic [tcsr_pkg::RATIO_W-1:0]      prog_ratio,
  input  wire logic                              cal_start,
  input  wire logic                              comp_tick,
  input  wire logic [tcsr_pkg::ADDR_W-1:0]       dev_addr,
  // Analog status, asynchronous
  input  wire logic                              lock_raw,
  input  wire logic                              tune_high_raw,
  input  wire logic                              tune_low_raw,
  input  wire logic                              supply_low_raw,
  input  wire logic [tcsr_pkg::LEVEL_W-1:0]      input_power_raw,
  // Two-wire read port
  input  wire logic                              scl_in,
  input  wire logic                              sda_in,
  output logic                                   sda_out,
  output logic                                   sda_oe_b,
  // Analog settings
  output logic [tcsr_pkg::BOOST_W-1:0]           boost_step,
  output logic [tcsr_pkg::CUTOFF_MHZ_W-1:0]      cutoff_mhz,
  output logic                                   lna_atten,
  output logic                                   loop_atten,
  output logic                                   pump_high_current,
  output logic                                   main_sink_on,
  output logic                                   main_source_on,
  output logic                                   second_sink_on,
  output logic                                   second_source_on,
  output logic                                   first_pump_en,
  output logic                                   second_pump_en,
  output logic [tcsr_pkg::SWING_W-1:0]           swing_out,
  output logic [tcsr_pkg::THRESH_W-1:0]          upper_threshold,
  output logic [tcsr_pkg::THRESH_W-1:0]          lower_threshold,
  output logic [tcsr_pkg::BIAS_W-1:0]            bias_out,
  output logic [1:0]                             port_out,
  output logic [1:0]                             port_oe_b,
  // Calibration
  output logic [tcsr_pkg::RATIO_W-1:0]           live_ratio_code,
  output logic                                   calibration_fault,
  output logic                                   cal_busy
);
  import tcsr_pkg::*;

  // Two-flop synchronisers; only stage two is read by logic
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  logic [SYNC_W-1:0] sync_nxt;
  logic              scl_s;
  logic              sda_s;
  logic              lock_s;
  logic              high_s;
  logic              low_s;
  logic              vlow_s;
  logic [LEVEL_W-1:0] level_s;
  logic              scl_d_r;
  logic              sda_d_r;

  always_comb begin
    sync_nxt = {input_power_raw, supply_low_raw, tune_low_raw, tune_high_raw,
                lock_raw, sda_in, scl_in};
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= {SYNC_W{1'b1}};
      sync2_r <= {SYNC_W{1'b1}};
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      sync1_r <= sync_nxt;
      sync2_r <= sync1_r;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign {level_s, vlow_s, low_s, high_s, lock_s, sda_s, scl_s} = sync2_r;

  // Analog setting decode
  function automatic logic [BOOST_W-1:0] boost_map(input logic [BOOST_W-1:0] c);
    boost_map = (c <= BOOST_FLAT_MAX) ? '0 : BOOST_W'(c - BOOST_FLAT_MAX);
  endfunction : boost_map

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      boost_step        <= '0;
      cutoff_mhz        <= CUTOFF_BASE_MHZ;
      lna_atten         <= 1'b0;
      loop_atten        <= 1'b0;
      pump_high_current <= 1'b0;
      main_sink_on      <= 1'b0;
      main_source_on    <= 1'b0;
      second_sink_on    <= 1'b0;
      second_source_on  <= 1'b0;
      first_pump_en     <= 1'b1;
      second_pump_en    <= 1'b0;
      swing_out         <= '0;
      upper_threshold   <= '0;
      lower_threshold   <= '0;
      bias_out          <= '0;
      port_out          <= '0;
      port_oe_b         <= '1;
    end else begin
      boost_step        <= boost_map(baseband_boost); // R1
      cutoff_mhz        <= CUTOFF_MHZ_W'(cutoff_code) + CUTOFF_BASE_MHZ; // R2
      lna_atten         <= input_pad; // R3
      loop_atten        <= input_pad; // R3
      pump_high_current <= pump_current_sel; // R4
      main_sink_on      <= main_pump_test & force_sink; // R5
      main_source_on    <= main_pump_test & force_source; // R5
      second_sink_on    <= second_pump_test & ~second_pump_force; // R6
      second_source_on  <= second_pump_test & second_pump_force; // R6
      first_pump_en     <= ~pump_select; // R7
      second_pump_en    <= pump_select; // R7
      // Passed through unchecked; the master owns the only legal value
      swing_out         <= oscillator_swing; // R8
      upper_threshold   <= upper_threshold_sel; // R11
      lower_threshold   <= lower_threshold_sel; // R12
      bias_out          <= baseband_bias_trim; // R13
      port_out          <= '0;
      port_oe_b         <= ~port_ctrl; // R9
    end
  end

  // Calibration sequencer
  tcsr_cal_e               cal_st_r;
  tcsr_cal_e               cal_st_nxt;
  logic [SETTLE_CNT_W-1:0] wait_r;
  logic [SETTLE_CNT_W-1:0] wait_nxt;
  logic [RATIO_W-1:0]      ratio_r;
  logic [RATIO_W-1:0]      ratio_nxt;
  logic                    fault_r;
  logic                    fault_nxt;
  logic [SETTLE_CNT_W-1:0] settle_len;

  assign settle_len = settle_select ? SETTLE_CNT_W'(LONG_SETTLE)
                                    : SETTLE_CNT_W'(SHORT_SETTLE); // R10

  always_comb begin
    cal_st_nxt = cal_st_r;
    wait_nxt   = wait_r;
    ratio_nxt  = ratio_r;
    fault_nxt  = fault_r;
    case (cal_st_r)
      TCSR_CAL_IDLE: begin
        if (cal_manual) begin
          ratio_nxt = prog_ratio; // R19
        end else if (cal_start) begin
          ratio_nxt  = prog_ratio;
          fault_nxt  = 1'b0;
          wait_nxt   = '0;
          cal_st_nxt = TCSR_CAL_WAIT;
        end
      end
      TCSR_CAL_WAIT: begin
        if (comp_tick) begin
          wait_nxt = SETTLE_CNT_W'(wait_r + 1'b1);
          if (SETTLE_CNT_W'(wait_r + 1'b1) == settle_len) begin
            cal_st_nxt = TCSR_CAL_JUDGE; // R10
          end
        end
      end
      TCSR_CAL_JUDGE: begin
        wait_nxt   = '0;
        cal_st_nxt = TCSR_CAL_IDLE;
        // Tuning voltage too high means the ratio must rise, too low fall
        if (high_s) begin
          if (ratio_r == RATIO_MAX) begin
            fault_nxt = 1'b1; // R18
          end else begin
            ratio_nxt  = ratio_r + 1'b1;
            cal_st_nxt = TCSR_CAL_WAIT;
          end
        end else if (low_s) begin
          if (ratio_r == RATIO_MIN) begin
            fault_nxt = 1'b1; // R18
          end else begin
            ratio_nxt  = ratio_r - 1'b1;
            cal_st_nxt = TCSR_CAL_WAIT;
          end
        end
      end
      default: cal_st_nxt = TCSR_CAL_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_st_r          <= TCSR_CAL_IDLE;
      wait_r            <= '0;
      ratio_r           <= '0;
      fault_r           <= 1'b0;
      live_ratio_code   <= '0;
      calibration_fault <= 1'b0;
      cal_busy          <= 1'b0;
    end else begin
      cal_st_r          <= cal_st_nxt;
      wait_r            <= wait_nxt;
      ratio_r           <= ratio_nxt;
      fault_r           <= fault_nxt;
      live_ratio_code   <= ratio_nxt; // R19
      calibration_fault <= fault_nxt;
      cal_busy          <= (cal_st_nxt != TCSR_CAL_IDLE);
    end
  end

  // Two-wire read port
  tcsr_ser_e    ser_st_r;
  tcsr_ser_e    ser_st_nxt;
  logic [2:0]   bit_r;
  logic [2:0]   bit_nxt;
  logic [7:0]   shift_r;
  logic [7:0]   shift_nxt;
  logic         byte_r;
  logic         byte_nxt;
  logic         drive_nxt;
  logic [15:0]  snap_r;
  logic [15:0]  snap_nxt;
  logic         done_r;
  logic         done_nxt;
  logic         por_r;
  logic         por_nxt;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_cond;
  logic         stop_cond;

  assign scl_rise   = scl_s & ~scl_d_r;
  assign scl_fall   = ~scl_s & scl_d_r;
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s; // R14
  assign stop_cond  = scl_s & scl_d_r & ~sda_d_r & sda_s; // R14

  always_comb begin
    ser_st_nxt = ser_st_r;
    bit_nxt    = bit_r;
    shift_nxt  = shift_r;
    byte_nxt   = byte_r;
    drive_nxt  = ~sda_oe_b;
    snap_nxt   = snap_r;
    done_nxt   = done_r;
    por_nxt    = por_r;
    if (start_cond) begin
      ser_st_nxt = TCSR_SER_ADDR;
      bit_nxt    = '0;
      // Leftover bits of the last frame could pose as a complete address
      shift_nxt  = '0;
      byte_nxt   = REG_STATUS_FLAGS;
      drive_nxt  = 1'b0;
      done_nxt   = 1'b0;
      snap_nxt   = '0; // R20
      snap_nxt[8+POS_POWER_ON]  = por_r; // R15
      snap_nxt[8+POS_LOCK]      = lock_s;
      snap_nxt[8+POS_TUNE_HIGH] = high_s;
      snap_nxt[8+POS_TUNE_LOW]  = low_s;
      snap_nxt[8+POS_CAL_FAULT] = fault_r;
      snap_nxt[8+2:8]           = STATUS_UNDEF;
      snap_nxt[POS_MARKER]      = 1'b1; // R16
      snap_nxt[POS_LEVEL_LSB +: LEVEL_W] = level_s;
      snap_nxt[POS_RATIO_LSB +: RATIO_W] = ratio_r;
    end else if (stop_cond) begin
      ser_st_nxt = TCSR_SER_IDLE;
      drive_nxt  = 1'b0;
      if (done_r) begin
        por_nxt  = 1'b0; // R17
        done_nxt = 1'b0;
      end
    end else begin
      case (ser_st_r)
        TCSR_SER_IDLE: drive_nxt = 1'b0;
        TCSR_SER_ADDR: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s};
            bit_nxt   = bit_r + 1'b1;
          end else if (scl_fall && bit_r == '0 && shift_r != '0) begin
            // Only reads to our address are answered; writes belong elsewhere
            if (shift_r[7:1] == dev_addr && shift_r[0]) begin
              drive_nxt  = 1'b1;
              ser_st_nxt = TCSR_SER_AACK;
            end else begin
              ser_st_nxt = TCSR_SER_IDLE;
            end
          end
        end
        TCSR_SER_AACK, TCSR_SER_MACK: begin
          if (scl_rise && ser_st_r == TCSR_SER_MACK && sda_s) begin
            ser_st_nxt = TCSR_SER_IDLE; // master declined further data
          end else if (scl_fall) begin
            if (ser_st_r == TCSR_SER_MACK && byte_r == REG_LEVEL_RATIO) begin
              drive_nxt  = 1'b0;
              ser_st_nxt = TCSR_SER_IDLE;
            end else begin
              shift_nxt  = (ser_st_r == TCSR_SER_AACK) ? snap_r[15:8] : snap_r[7:0];
              byte_nxt   = (ser_st_r == TCSR_SER_AACK) ? REG_STATUS_FLAGS
                                                       : REG_LEVEL_RATIO;
              drive_nxt  = ~((ser_st_r == TCSR_SER_AACK) ? snap_r[15] : snap_r[7]);
              bit_nxt    = '0;
              ser_st_nxt = TCSR_SER_TX;
            end
          end
        end
        TCSR_SER_TX: begin
          if (scl_fall) begin
            if (bit_r == LAST_BIT) begin
              drive_nxt  = 1'b0;
              ser_st_nxt = TCSR_SER_MACK;
              if (byte_r == REG_LEVEL_RATIO) begin
                done_nxt = 1'b1;
              end
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              drive_nxt = ~shift_r[6]; // R16
              bit_nxt   = bit_r + 1'b1;
            end
          end
        end
        default: ser_st_nxt = TCSR_SER_IDLE;
      endcase
    end
    // A supply dip in the clearing cycle still leaves the flag set
    if (vlow_s) begin
      por_nxt = 1'b1; // R17
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_st_r <= TCSR_SER_IDLE;
      bit_r    <= '0;
      shift_r  <= '0;
      byte_r   <= REG_STATUS_FLAGS;
      snap_r   <= '0;
      done_r   <= 1'b0;
      por_r    <= 1'b1; // R17
      sda_out  <= 1'b0;
      sda_oe_b <= 1'b1;
    end else begin
      ser_st_r <= ser_st_nxt;
      bit_r    <= bit_nxt;
      shift_r  <= shift_nxt;
      byte_r   <= byte_nxt;
      snap_r   <= snap_nxt;
      done_r   <= done_nxt;
      por_r    <= por_nxt;
      sda_out  <= 1'b0;
      sda_oe_b <= ~drive_nxt;
    end
  end

endmodule : tcsr_top

// [sim/tcsr_monitor.sv]
// Checker of the tuner control block: decode, pump forcing, ports, calibration.
// Assumes it is bound into tcsr_top and sees only that module's ports.
`timescale 1ns/1ps
module tcsr_monitor (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rst_b,
  // Control inputs
  input wire logic [3:0] baseband_boost,
  input wire logic [4:0] cutoff_code,
  input wire logic       input_pad,
  input wire logic       main_pump_test,
  input wire logic       force_sink,
  input wire logic       force_source,
  input wire logic       second_pump_test,
  input wire logic       second_pump_force,
  input wire logic       pump_select,
  input wire logic [1:0] port_ctrl,
  input wire logic       cal_start,
  input wire logic       cal_manual,
  input wire logic [4:0] prog_ratio,
  // Outputs
  input wire logic [3:0] boost_step,
  input wire logic [5:0] cutoff_mhz,
  input wire logic       lna_atten,
  input wire logic       loop_atten,
  input wire logic       main_sink_on,
  input wire logic       main_source_on,
  input wire logic       second_sink_on,
  input wire logic       second_source_on,
  input wire logic       first_pump_en,
  input wire logic       second_pump_en,
  input wire logic [1:0] port_out,
  input wire logic [1:0] port_oe_b,
  input wire logic [4:0] live_ratio_code,
  input wire logic       calibration_fault,
  input wire logic       cal_busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // A start is only taken when the sequencer is idle and not in manual mode
  sequence cal_go_s;
    cal_start && !cal_manual && !cal_busy;
  endsequence

  // Registered outputs: the $past(rst_b) guard of the six decode checks skips the edge whose past still saw reset
  boost_decode_a: assert property ($past(rst_b) |-> boost_step ==
    (($past(baseband_boost) <= 4'h4) ? 4'h0 : $past(baseband_boost) - 4'h4))
    else $error("boost step wrong");
  cutoff_map_a: assert property ($past(rst_b) |->
    cutoff_mhz == {1'b0, $past(cutoff_code)} + 6'h05) else $error("cut-off wrong");
  pad_atten_a: assert property ($past(rst_b) |->
    lna_atten == $past(input_pad) && loop_atten == lna_atten) else $error("pad wrong");
  main_force_a: assert property ($past(rst_b) |-> {main_sink_on, main_source_on} ==
    ($past(main_pump_test) ? {$past(force_sink), $past(force_source)} : 2'h0))
    else $error("main pump forcing wrong");
  second_force_a: assert property ($past(rst_b) && $past(second_pump_test) |->
    second_source_on == $past(second_pump_force) && second_sink_on != second_source_on)
    else $error("second pump forcing wrong");
  pump_choice_a: assert property ($past(rst_b) |-> second_pump_en == $past(pump_select)
    && first_pump_en != second_pump_en) else $error("pump choice wrong");
  port_sink_a: assert property ($changed(port_ctrl) |=>
    port_oe_b == ~$past(port_ctrl) && port_out == 2'h0) else $error("port drive wrong");
  cal_launch_a: assert property (cal_go_s |=>
    cal_busy && live_ratio_code == $past(prog_ratio) && !calibration_fault)
    else $error("calibration start wrong");
  fault_hold_a: assert property (calibration_fault && !cal_start |=>
    calibration_fault) else $error("fault flag dropped");
endmodule : tcsr_monitor

// [sim/tcsr_master.sv]
// Two-wire bus master model that reads the tuner status bytes.
// Assumes SDA is resolved outside with a pull-up; tasks start on a falling sys_clk edge.
`timescale 1ns/1ps
module tcsr_master (
  // Bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;  // Clock stands high between frames
    sda_low = 1'b0;
  end

  // Data changes mid low phase, well clear of the synchronised clock fall
  task automatic slot(input logic pull, output logic seen);
    sda_low = pull;
    #40;
    scl = 1'b1;
    seen = sda;
    #80;
    scl = 1'b0;
    #40;
  endtask : slot

  task automatic xfer(input logic [7:0] head, output logic ack, output logic [15:0] data);
    logic b;
    sda_low = 1'b1;
    #80;
    scl = 1'b0;
    #40;
    for (int i = 7; i >= 0; i--) slot(!head[i], b);
    slot(1'b0, ack);
    for (int i = 15; i >= 0; i--) begin
      slot(1'b0, data[i]);
      if (i % 8 == 0) slot(1'b1, b);
    end
    sda_low = 1'b1;
    #40;
    scl = 1'b1;
    #80;
    sda_low = 1'b0;
    #80;
  endtask : xfer
endmodule : tcsr_master

// [sim/tcsr_top_test.sv]
// Self-checking bench of the tuner control and status block.
// Assumes the master model owns SCL; SDA has a pull-up and is resolved here.
`timescale 1ns/1ps
module tcsr_top_test;
  import tcsr_pkg::*;
  logic sys_clk, rst_b, input_pad, pump_current_sel, main_pump_test, force_sink, force_source;
  logic second_pump_test, second_pump_force, pump_select, settle_select, cal_manual, cal_start;
  logic comp_tick, lock_raw, tune_high_raw, tune_low_raw, supply_low_raw, scl_in, sda_in;
  logic sda_out, sda_oe_b, lna_atten, loop_atten, pump_high_current, main_sink_on;
  logic main_source_on, second_sink_on, second_source_on, first_pump_en, second_pump_en;
  logic calibration_fault, cal_busy, sda_low, ack;
  logic [3:0]  baseband_boost, baseband_bias_trim, boost_step, bias_out;
  logic [4:0]  cutoff_code, prog_ratio, live_ratio_code;
  logic [5:0]  cutoff_mhz;
  logic [2:0]  oscillator_swing, swing_out;
  logic [1:0]  port_ctrl, upper_threshold_sel, lower_threshold_sel, input_power_raw;
  logic [1:0]  port_out, port_oe_b, upper_threshold, lower_threshold;
  logic [6:0]  dev_addr;
  logic [15:0] rd;
  logic [31:0] r;
  int          mismatches, checked, cycles;

  // Settle counts shortened so a calibration step takes a few ticks
  tcsr_top #(.SHORT_SETTLE(5), .LONG_SETTLE(7)) i_tcsr_top (.*);
  tcsr_master i_tcsr_master (.scl(scl_in), .sda_low(sda_low), .sda(sda_in));
  assign sda_in = !(sda_low || !sda_oe_b);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  function automatic logic [3:0] exp_boost(input logic [3:0] c);
    return (c <= 4'h4) ? 4'h0 : c - 4'h4;
  endfunction : exp_boost

  task automatic drive_ctrl(input int i);
    @(negedge sys_clk);
    r = $urandom();
    cutoff_code = i[4:0];
    baseband_boost = i[3:0];
    {input_pad, pump_current_sel, main_pump_test, force_sink, force_source, second_pump_test,
     second_pump_force, pump_select, port_ctrl, upper_threshold_sel, lower_threshold_sel} = r[13:0];
    @(negedge sys_clk);
    check("boost", boost_step, exp_boost(baseband_boost));
    check("cutoff", cutoff_mhz, cutoff_code + 6'h05);
    check("pad", {lna_atten, loop_atten}, {2{input_pad}});
    check("current", pump_high_current, pump_current_sel);
    check("main", {main_sink_on, main_source_on},
          {2{main_pump_test}} & {force_sink, force_source});
    check("second", {second_sink_on, second_source_on},
          second_pump_test ? {!second_pump_force, second_pump_force} : 2'h0);
    check("pumps", {first_pump_en, second_pump_en}, {!pump_select, pump_select});
    check("ports", {port_out, port_oe_b}, {2'h0, ~port_ctrl});
    check("thresh", {upper_threshold, lower_threshold},
          {upper_threshold_sel, lower_threshold_sel});
    check("trims", {swing_out, bias_out}, {3'h4, 4'hD});
  endtask : drive_ctrl

  task automatic read_frame(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] m1);
    @(negedge sys_clk);
    i_tcsr_master.xfer({dev_addr, 1'b1}, ack, rd);
    check("read ack", ack, 1'b0);
    check("sda level", sda_out, 1'b0);
    check("byte0", rd[15:11], e0[7:3]);
    check("byte1", rd[7:0] & m1, e1 & m1);
  endtask : read_frame

  task automatic tick(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      comp_tick = 1'b1;
      @(negedge sys_clk);
      comp_tick = 1'b0;
    end
    repeat (3) @(negedge sys_clk);
  endtask : tick

  initial begin
    void'($urandom(32'h752E));
    rst_b = 1'b0;
    {input_pad, pump_current_sel, main_pump_test, force_sink, force_source, second_pump_test,
     second_pump_force, pump_select, settle_select, cal_start, comp_tick, lock_raw,
     tune_high_raw, tune_low_raw, supply_low_raw, baseband_boost, cutoff_code, port_ctrl,
     upper_threshold_sel, lower_threshold_sel, input_power_raw, prog_ratio} = '0;
    cal_manual = 1'b1;
    oscillator_swing = 3'h4;
    baseband_bias_trim = 4'hD;
    dev_addr = 7'h2A;
    repeat (5) @(negedge sys_clk);
    check("reset", {cutoff_mhz, first_pump_en, port_oe_b, sda_oe_b}, {6'h05, 4'hF});
    rst_b = 1'b1;
    for (int i = 0; i < 48; i++) drive_ctrl(i);
    // Power-on flag: set by reset, cleared by a read, set again by a supply dip
    for (int p = 0; p < 3; p++) begin
      @(negedge sys_clk);
      r = $urandom();
      {lock_raw, tune_high_raw, tune_low_raw, input_power_raw, prog_ratio} = r[9:0];
      supply_low_raw = (p == 2);
      repeat (6) @(negedge sys_clk);
      supply_low_raw = 1'b0;
      repeat (4) @(negedge sys_clk);
      read_frame({p != 1, lock_raw, tune_high_raw, tune_low_raw, 4'h0},
                 {1'b1, input_power_raw, prog_ratio}, 8'hFF);
    end
    for (int w = 0; w < 2; w++) begin
      @(negedge sys_clk);
      i_tcsr_master.xfer(w ? {dev_addr ^ 7'h01, 1'b1} : {dev_addr, 1'b0}, ack, rd);
      check("refused ack", ack, 1'b1);
      check("refused data", rd, 16'hFFFF);
    end
    // Auto calibration runs off each end of the ratio range
    cal_manual = 1'b0;
    for (int k = 0; k < 2; k++) begin
      @(negedge sys_clk);
      settle_select = k[0];
      prog_ratio = k ? 5'h01 : 5'h1E;
      {tune_high_raw, tune_low_raw} = k ? 2'b01 : 2'b10;
      repeat (4) @(negedge sys_clk);
      cal_start = 1'b1;
      @(negedge sys_clk);
      cal_start = 1'b0;
      tick(k ? 6 : 4);
      check("wait", live_ratio_code, prog_ratio);
      tick(1);
      check("step", {cal_busy, live_ratio_code}, {1'b1, k ? 5'h00 : 5'h1F});
      tick(k ? 7 : 5);
      check("fault", {calibration_fault, cal_busy}, 2'b10);
      read_frame({1'b0, lock_raw, tune_high_raw, tune_low_raw, 4'h8},
                 {1'b1, input_power_raw, (k ? 5'h00 : 5'h1F)}, 8'hFF);
    end
    conclude();
  end
endmodule : tcsr_top_test

bind tcsr_top tcsr_monitor i_tcsr_monitor (.*);
